// ---- src/gpb_pkg.sv ----
/*
 Package for the eight-pin port block: register offsets, field positions,
 reset values. Assumes a 32-bit APB slave with one aligned word per register.
*/
package gpb_pkg;
    localparam logic [11:0] OFF_PIN_VALUE = 12'h000;
    localparam logic [11:0] OFF_OUT_LATCH = 12'h004;
    localparam logic [11:0] OFF_DIRECTION = 12'h008;
    localparam logic [11:0] OFF_IRQ_MAIN = 12'h00C;
    localparam logic [11:0] OFF_IRQ_SECOND = 12'h010;
    localparam logic [11:0] OFF_IRQ_THIRD = 12'h014;
    localparam logic [11:0] OFF_ANALOG_SETUP = 12'h018;
    localparam logic [11:0] OFF_EVT_STATUS = 12'h01C;
    localparam logic [11:0] OFF_EVT_ENABLE = 12'h020;
    localparam logic [11:0] OFF_EVT_CLEAR = 12'h024;
    // Main control: enable at bit 3, port-change flag at bit 0
    localparam int MAIN_CHG_IE = 3;
    localparam int MAIN_CHG_IF = 0;
    localparam logic [7:0] MAIN_MASK = 8'hFB; // Bit 2 absent, bit 3 change enable kept
    // Second control: pull-up disable bit 7, change priority bit 0
    localparam int SEC_PU_DIS = 7;
    localparam int SEC_CHG_IP = 0;
    localparam logic [7:0] SEC_MASK = 8'hF5;
    localparam logic [7:0] SEC_RESET = 8'hF5;
    // Third control: ext irq two priority 7, enable 4, flag 1
    localparam int THR_EXT2_IP = 7;
    localparam int THR_EXT2_IE = 4;
    localparam int THR_EXT2_IF = 1;
    localparam logic [7:0] THR_MASK = 8'hDB;
    localparam logic [7:0] THR_RESET = 8'hC0;
    // Analog setup: config nibble low, upper two bits unimplemented
    localparam logic [7:0] ANA_MASK = 8'h3F;
    localparam logic [3:0] ANA_CFG_ALL_ANALOG = 4'h0;
    localparam logic [3:0] ANA_CFG_ALL_DIGITAL = 4'h7;
    localparam logic [7:0] DIR_RESET = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // Event bits: port change, ext irq two edge
    localparam int EVT_CHG = 0;
    localparam int EVT_EXT2 = 1;
    localparam int EVT_W = 2;
    localparam int CHG_LO = 4;
    localparam int ANA_PINS = 5;
    localparam int PIN_EXT2 = 2;
    localparam int PIN_CAP2 = 3;
    localparam int PIN_PROG = 5;
    localparam int PIN_PCLK = 6;
    localparam int PIN_PDAT = 7;
endpackage

// ---- src/gpb_port.sv ----
/*
 Eight-pin bidirectional port with pull-up, analog select, change and
 external interrupts, capture/compare and programming overrides.
 Assumes an APB master on ref_clk; pins arrive asynchronously.
*/
// Our own choices: the APB register port and the register offsets.
// Summary of operation
// - Output pins are driven from the output latch; analog select does not affect it.
// - Input pins release the driver; synced pin level reads from the pin-value register.
// - Pull-ups on inputs follow bit 7 of second control: clear enables, set disables.
// - Analog-selected low pins lose pull-up and digital input path.
// - Pins 4 to 7 detect changes only while configured as inputs.
// - Input pin 2 feeds external interrupt two in third control register.
// - Capture/compare two uses pin 3 only when its select bit is zero.
// - Routed capture/compare drives pin 3 when output, receives capture when input.
// - Low-voltage programming makes pin 5 entry-only, other functions off.
// - During programming pin 6 is serial clock, pin 7 serial data.
// - At reset low pins become analog if analog default bit is set.
// - Pull-up disable at bit 7, change priority bit 0, bits 3 and 1 absent.
// - Unimplemented control bits read as zero.
// - Output latch reads return latch contents; writes update the latch.
// - Inputs 4 to 7 compare to value captured at last pin read.
// - Mismatch keeps setting change flag until a pin read refreshes capture.
// - Pull-up is off on output pins and off during reset.
`timescale 1ns/1ps
module gpb_port
    import gpb_pkg::*;
#(
    parameter int PINS = 8
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Configuration straps
    input wire logic analog_default_at_por,
    input wire logic capture2_pin_select,
    input wire logic low_voltage_prog_enable,
    input wire logic prog_active,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Pins
    input wire logic [PINS-1:0] pinIn,
    output logic [PINS-1:0] pinOut,
    output logic [PINS-1:0] pinOe,
    output logic [PINS-1:0] pullupEn,
    output logic [ANA_PINS-1:0] analogSelect,
    // Capture/compare two and programming
    input wire logic capture2CmpOut,
    output logic capture2CapIn,
    output logic prog_mode_entry,
    output logic prog_serial_clock,
    output logic prog_serial_data_in,
    input wire logic progDataOut,
    input wire logic progDataOe,
    // Interrupt
    output logic irq
);
    logic [PINS-1:0] syncA_q, syncB_q;
    logic [PINS-1:0] latch_q, dir_q, oldVal_q;
    logic [7:0] main_q, sec_q, thr_q, ana_q;
    logic [EVT_W-1:0] evtStat_q, evtEn_q;
    logic ext2Prev_q, strapSeen_q;
    logic [PINS-1:0] pinOut_d, pinOe_d, pullup_d, digIn;
    logic [ANA_PINS-1:0] anaSel;
    logic wrEn, rdEn, pinRead, mismatch, ext2Edge, hit;
    logic [31:0] rdData;

    // Two-stage pin synchroniser
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            syncA_q <= BYTE_ZERO;
            syncB_q <= BYTE_ZERO;
        end
        else
        begin
            syncA_q <= pinIn;
            syncB_q <= syncA_q;
        end
    end

    assign wrEn = psel && penable && pwrite;
    assign rdEn = psel && penable && !pwrite;
    assign pinRead = rdEn && paddr == OFF_PIN_VALUE;

    // Analog select decode: config below 7 maps low pins analog
    always_comb
    begin
        for (int i = 0; i < ANA_PINS; i++)
            anaSel[i] = ana_q[3:0] < (ANA_CFG_ALL_DIGITAL - 4'(i));
    end

    // Digital input path, forced low on analog pins
    always_comb
    begin
        digIn = syncB_q;
        for (int i = 0; i < ANA_PINS; i++)
            if (anaSel[i])
                digIn[i] = 1'b0;
        if (low_voltage_prog_enable)
            digIn[PIN_PROG] = 1'b0;
        if (prog_active)
        begin
            digIn[PIN_PCLK] = 1'b0;
            digIn[PIN_PDAT] = 1'b0;
        end
    end

    // Pin drive, pull-up and override resolution
    always_comb
    begin
        pinOut_d = latch_q;
        pinOe_d = ~dir_q;
        for (int i = 0; i < PINS; i++)
            pullup_d[i] = dir_q[i] && !sec_q[SEC_PU_DIS];
        for (int i = 0; i < ANA_PINS; i++)
            if (anaSel[i])
                pullup_d[i] = 1'b0;
        if (!capture2_pin_select && !dir_q[PIN_CAP2])
            pinOut_d[PIN_CAP2] = capture2CmpOut;
        if (low_voltage_prog_enable)
        begin
            pinOe_d[PIN_PROG] = 1'b0;
            pullup_d[PIN_PROG] = 1'b0;
        end
        if (prog_active)
        begin
            pinOe_d[PIN_PCLK] = 1'b0;
            pullup_d[PIN_PCLK] = 1'b0;
            pinOe_d[PIN_PDAT] = progDataOe;
            pinOut_d[PIN_PDAT] = progDataOut;
            pullup_d[PIN_PDAT] = 1'b0;
        end
    end

    // Registered pin outputs
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            pinOut <= BYTE_ZERO;
            pinOe <= BYTE_ZERO;
            pullupEn <= BYTE_ZERO;
            analogSelect <= '0;
            capture2CapIn <= 1'b0;
            prog_mode_entry <= 1'b0;
            prog_serial_clock <= 1'b0;
            prog_serial_data_in <= 1'b0;
        end
        else
        begin
            pinOut <= pinOut_d;
            pinOe <= pinOe_d;
            pullupEn <= pullup_d;
            analogSelect <= anaSel;
            capture2CapIn <= !capture2_pin_select && dir_q[PIN_CAP2] && syncB_q[PIN_CAP2];
            prog_mode_entry <= low_voltage_prog_enable && syncB_q[PIN_PROG];
            prog_serial_clock <= prog_active && syncB_q[PIN_PCLK];
            prog_serial_data_in <= prog_active && syncB_q[PIN_PDAT];
        end
    end

    // Output latch and direction; pin-value writes go to the latch
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            latch_q <= BYTE_ZERO;
            dir_q <= DIR_RESET;
        end
        else if (wrEn)
        begin
            if (paddr == OFF_PIN_VALUE || paddr == OFF_OUT_LATCH)
                latch_q <= pwdata[PINS-1:0];
            if (paddr == OFF_DIRECTION)
                dir_q <= pwdata[PINS-1:0];
        end
    end

    // Analog setup; reset value taken from strap after release
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            ana_q <= {BYTE_ZERO[7:4], ANA_CFG_ALL_DIGITAL};
            strapSeen_q <= 1'b0;
        end
        else if (!strapSeen_q)
        begin
            strapSeen_q <= 1'b1;
            ana_q <= {BYTE_ZERO[7:4], analog_default_at_por ? ANA_CFG_ALL_ANALOG
                                                             : ANA_CFG_ALL_DIGITAL};
        end
        else if (wrEn && paddr == OFF_ANALOG_SETUP)
            ana_q <= pwdata[7:0] & ANA_MASK;
    end

    // Value captured on each pin-value read
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            oldVal_q <= BYTE_ZERO;
        else if (pinRead)
            oldVal_q <= digIn;
    end

    // Mismatch on inputs 4 to 7 only
    always_comb
    begin
        mismatch = 1'b0;
        for (int i = CHG_LO; i < PINS; i++)
            mismatch = mismatch | (dir_q[i] && digIn[i] != oldVal_q[i]);
    end

    assign ext2Edge = dir_q[PIN_EXT2] && digIn[PIN_EXT2] && !ext2Prev_q;

    // Previous level of external interrupt two input
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            ext2Prev_q <= 1'b0;
        else
            ext2Prev_q <= dir_q[PIN_EXT2] && digIn[PIN_EXT2];
    end

    // Main control; hardware set wins over software clear
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            main_q <= BYTE_ZERO;
        else
        begin
            if (wrEn && paddr == OFF_IRQ_MAIN)
                main_q <= pwdata[7:0] & MAIN_MASK;
            if (mismatch)
                main_q[MAIN_CHG_IF] <= 1'b1;
        end
    end

    // Second control register
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            sec_q <= SEC_RESET;
        else if (wrEn && paddr == OFF_IRQ_SECOND)
            sec_q <= pwdata[7:0] & SEC_MASK;
    end

    // Third control; external two flag set wins
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            thr_q <= THR_RESET;
        else
        begin
            if (wrEn && paddr == OFF_IRQ_THIRD)
                thr_q <= pwdata[7:0] & THR_MASK;
            if (ext2Edge)
                thr_q[THR_EXT2_IF] <= 1'b1;
        end
    end

    // Sticky event status, enable, write-one clear
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            evtStat_q <= '0;
            evtEn_q <= '0;
        end
        else
        begin
            if (wrEn && paddr == OFF_EVT_ENABLE)
                evtEn_q <= pwdata[EVT_W-1:0];
            for (int i = 0; i < EVT_W; i++)
                if (wrEn && paddr == OFF_EVT_CLEAR && pwdata[i])
                    evtStat_q[i] <= 1'b0;
            if (mismatch)
                evtStat_q[EVT_CHG] <= 1'b1;
            if (ext2Edge)
                evtStat_q[EVT_EXT2] <= 1'b1;
        end
    end

    // Read decode
    always_comb
    begin
        rdData = 32'h0000_0000;
        hit = 1'b1;
        if (paddr == OFF_PIN_VALUE)
            rdData[PINS-1:0] = digIn;
        else if (paddr == OFF_OUT_LATCH)
            rdData[PINS-1:0] = latch_q;
        else if (paddr == OFF_DIRECTION)
            rdData[PINS-1:0] = dir_q;
        else if (paddr == OFF_IRQ_MAIN)
            rdData[7:0] = main_q;
        else if (paddr == OFF_IRQ_SECOND)
            rdData[7:0] = sec_q;
        else if (paddr == OFF_IRQ_THIRD)
            rdData[7:0] = thr_q;
        else if (paddr == OFF_ANALOG_SETUP)
            rdData[7:0] = ana_q;
        else if (paddr == OFF_EVT_STATUS)
            rdData[EVT_W-1:0] = evtStat_q;
        else if (paddr == OFF_EVT_ENABLE)
            rdData[EVT_W-1:0] = evtEn_q;
        else if (paddr == OFF_EVT_CLEAR)
            rdData = 32'h0000_0000;
        else
            hit = 1'b0;
    end

    // APB answer registered: ready one cycle after setup phase starts
    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !hit;
            if (psel && !penable && !pwrite)
                prdata <= rdData;
        end
    end

    // Interrupt output
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(evtStat_q & evtEn_q);
    end
endmodule

// ---- bench/gpb_port_sva.sv ----
/*
 Checker for the eight-pin port: bus handshake, pull-up and override timing.
 Assumes it is bound to gpb_port and sees only that module's ports.
*/
`timescale 1ns/1ps
module gpb_port_sva
    import gpb_pkg::*;
#(
    parameter int PINS = 8
)
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic reset,
    // Straps and bus
    input wire logic analog_default_at_por,
    input wire logic capture2_pin_select,
    input wire logic low_voltage_prog_enable,
    input wire logic prog_active,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    // Pins and overrides
    input wire logic [PINS-1:0] pinIn,
    input wire logic [PINS-1:0] pinOut,
    input wire logic [PINS-1:0] pinOe,
    input wire logic [PINS-1:0] pullupEn,
    input wire logic [ANA_PINS-1:0] analogSelect,
    input wire logic capture2CmpOut,
    input wire logic prog_mode_entry,
    input wire logic prog_serial_clock,
    input wire logic irq
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    // Bus answers
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    // Pull-up gating
    chk_pullup_output: assert property ((pullupEn & pinOe) == '0)
        else $error("pull-up on output pin");
    chk_pullup_analog: assert property ((pullupEn[ANA_PINS-1:0] & analogSelect) == '0)
        else $error("pull-up on analog pin");
    chk_reset_quiet: assert property (disable iff (1'b0) reset |=> pinOe == '0 && pullupEn == '0)
        else $error("pins active in reset");
    chk_strap_default: assert property ($fell(reset) |-> ##[1:3] analogSelect == {ANA_PINS{analog_default_at_por}})
        else $error("analog default wrong");
    // Pin overrides
    chk_entry_pin: assert property ((low_voltage_prog_enable && $stable(pinIn[5]))[*5]
        |-> prog_mode_entry == pinIn[5] && !pinOe[5] && !pullupEn[5])
        else $error("entry pin wrong");
    chk_prog_clock: assert property ((prog_active && $stable(pinIn[6]))[*5]
        |-> prog_serial_clock == pinIn[6] && !pinOe[6])
        else $error("prog clock wrong");
    chk_cap_route: assert property ((!capture2_pin_select && pinOe[3] && $stable(capture2CmpOut))[*4]
        |-> pinOut[3] == capture2CmpOut)
        else $error("compare output not on pin");
    // Main scenarios
    cover property (pslverr);
    cover property ($rose(irq));
    cover property (prog_active && prog_serial_clock);
endmodule

bind gpb_port gpb_port_sva #(.PINS(PINS)) gpb_port_sva_i (.ref_clk, .reset, .analog_default_at_por,
    .capture2_pin_select, .low_voltage_prog_enable, .prog_active, .psel, .penable, .pready, .pslverr,
    .pinIn, .pinOut, .pinOe, .pullupEn, .analogSelect, .capture2CmpOut, .prog_mode_entry,
    .prog_serial_clock, .irq);

// ---- bench/gpb_board.sv ----
/*
 Board model for the eight port pins: resolves each pin level.
 Assumes the bench drives its own pin values right after clock edges.
*/
`timescale 1ns/1ps
module gpb_board
(
    // Clock
    input wire logic ref_clk,
    // Device side
    input wire logic [7:0] pinOut,
    input wire logic [7:0] pinOe,
    input wire logic [7:0] pullupEn,
    // Bench side
    input wire logic [7:0] extOe,
    input wire logic [7:0] extVal,
    output logic [7:0] pinIn
);
    logic [7:0] floatQ = 8'h00;
    // Undriven lines without pull-up wander
    always @(posedge ref_clk)
    begin
        floatQ <= ~floatQ;
    end
    // Device drive first, then board, then pull-up
    always_comb
    begin
        for (int i = 0; i < 8; i++)
        begin
            pinIn[i] = pinOe[i] ? pinOut[i] : extOe[i] ? extVal[i] : pullupEn[i] ? 1'b1 : floatQ[i];
        end
    end
endmodule

// ---- bench/gpb_port_tb_top.sv ----
/*
 Self-checking bench for the port: registers, pins, events, overrides.
 Assumes gpb_port, gpb_board and the bound checker are compiled first.
*/
`timescale 1ns/1ps
module gpb_port_tb_top
    import gpb_pkg::*;
;
    logic ref_clk = 0, reset = 1, analog_default_at_por = 1, capture2_pin_select = 1;
    logic low_voltage_prog_enable = 0, prog_active = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rdat;
    logic pready, pslverr, errFlag, capture2CmpOut = 0, capture2CapIn, prog_mode_entry;
    logic prog_serial_clock, prog_serial_data_in, progDataOut = 0, progDataOe = 0, irq;
    logic [7:0] pinIn, pinOut, pinOe, pullupEn, extOe = 8'hFF, extVal = 8'h00, lat;
    logic [4:0] analogSelect;
    int errTotal = 0, samplesChecked = 0, cyc = 0;
    logic [11:0] wa[4] = '{OFF_IRQ_MAIN, OFF_IRQ_SECOND, OFF_IRQ_THIRD, OFF_ANALOG_SETUP};
    logic [7:0] wm[4] = '{MAIN_MASK, SEC_MASK, THR_MASK, ANA_MASK};

    gpb_port gpb_port_i (.ref_clk, .reset, .analog_default_at_por, .capture2_pin_select,
        .low_voltage_prog_enable, .prog_active, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .pinIn, .pinOut, .pinOe, .pullupEn, .analogSelect, .capture2CmpOut,
        .capture2CapIn, .prog_mode_entry, .prog_serial_clock, .prog_serial_data_in, .progDataOut,
        .progDataOe, .irq);
    gpb_board gpb_board_i (.ref_clk, .pinOut, .pinOe, .pullupEn, .extOe, .extVal, .pinIn);

    // Clock and hang limit
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            errTotal++;
            results();
        end
    end

    // One APB transfer, then an idle cycle
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rdat = prdata;
        errFlag = pslverr;
        psel <= 0;
        penable <= 0;
        @(posedge ref_clk);
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samplesChecked++;
        if (got !== exp)
        begin
            errTotal++;
            $display("ERROR %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic results();
        if (errTotal == 0 && samplesChecked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        void'($urandom(32'hD8A0));
        repeat (5) @(posedge ref_clk);
        reset <= 0;
        repeat (3) @(posedge ref_clk);
        apb(0, OFF_IRQ_SECOND, 0);
        chk(rdat, SEC_RESET);
        apb(0, OFF_IRQ_THIRD, 0);
        chk(rdat, THR_RESET);
        apb(0, OFF_DIRECTION, 0);
        chk(rdat, DIR_RESET);
        apb(0, OFF_ANALOG_SETUP, 0);
        chk(rdat, ANA_CFG_ALL_ANALOG);
        foreach (wa[i])
        begin
            apb(1, wa[i], 32'hFFFFFFFF);
            apb(0, wa[i], 0);
            chk(rdat, wm[i]);
        end
        apb(1, OFF_IRQ_MAIN, 0);
        apb(1, OFF_IRQ_THIRD, 0);
        apb(1, 12'h0FC, $urandom);
        chk(errFlag, 1);
        // Outputs follow the latch, analog or not
        extOe <= 8'h00;
        lat = 8'($urandom);
        apb(1, OFF_DIRECTION, 0);
        apb(1, OFF_OUT_LATCH, lat);
        apb(0, OFF_OUT_LATCH, 0);
        chk(rdat, lat);
        apb(1, OFF_ANALOG_SETUP, ANA_CFG_ALL_ANALOG);
        chk(pinOut, lat);
        chk(pinOe, 8'hFF);
        apb(1, OFF_ANALOG_SETUP, 32'h0F);
        // Pull-ups only on digital inputs with global enable
        apb(1, OFF_DIRECTION, 32'h0F);
        apb(1, OFF_IRQ_SECOND, 32'h75);
        @(posedge ref_clk);
        chk(pullupEn, 8'h0F);
        apb(1, OFF_IRQ_SECOND, SEC_RESET);
        @(posedge ref_clk);
        chk(pullupEn, 8'h00);
        // Pin levels read back after sync
        extOe <= 8'hFF;
        extVal <= 8'($urandom);
        apb(1, OFF_DIRECTION, 32'hFF);
        repeat (4) @(posedge ref_clk);
        apb(0, OFF_PIN_VALUE, 0);
        chk(rdat, extVal);
        // Change event holds until a pin read
        apb(1, OFF_EVT_ENABLE, 32'h3);
        apb(1, OFF_EVT_CLEAR, 32'h3);
        extVal <= extVal ^ 8'h10;
        repeat (5) @(posedge ref_clk);
        apb(1, OFF_EVT_CLEAR, 32'h1);
        apb(0, OFF_EVT_STATUS, 0);
        chk(rdat, 32'h1);
        chk(irq, 1);
        apb(0, OFF_PIN_VALUE, 0);
        apb(1, OFF_EVT_CLEAR, 32'h1);
        apb(0, OFF_EVT_STATUS, 0);
        chk(rdat, 0);
        // Rising edge on pin two
        extVal <= extVal & 8'hFB;
        repeat (5) @(posedge ref_clk);
        apb(1, OFF_EVT_CLEAR, 32'h3);
        extVal <= extVal | 8'h04;
        repeat (5) @(posedge ref_clk);
        apb(0, OFF_EVT_STATUS, 0);
        chk(rdat, 32'h2);
        // Overrides on pins 3, 5, 6 and 7
        capture2_pin_select <= 0;
        low_voltage_prog_enable <= 1;
        prog_active <= 1;
        extVal <= 8'($urandom);
        repeat (6) @(posedge ref_clk);
        chk(capture2CapIn, extVal[3]);
        chk(prog_mode_entry, extVal[5]);
        chk(prog_serial_clock, extVal[6]);
        chk(prog_serial_data_in, extVal[7]);
        // Programming data drives pin 7 regardless of direction
        progDataOe <= 1;
        progDataOut <= 1;
        repeat (2) @(posedge ref_clk);
        chk(pinOe[7], 1'b1);
        chk(pinOut[7], 1'b1);
        capture2CmpOut <= 1;
        apb(1, OFF_DIRECTION, 32'hF7);
        repeat (4) @(posedge ref_clk);
        chk(pinOut[3], 1'b1);
        chk(capture2CapIn, 1'b0);
        progDataOe <= 0;
        prog_active <= 0;
        low_voltage_prog_enable <= 0;
        // Second reset with strap clear
        reset <= 1;
        analog_default_at_por <= 0;
        repeat (5) @(posedge ref_clk);
        reset <= 0;
        repeat (4) @(posedge ref_clk);
        chk(analogSelect, 5'h00);
        results();
    end
endmodule
